// >>> bench/ivp_host.sv
`timescale 1ns/1ps
// host controller model: one command at a time, held until the ack edge
module ivp_host
   import ivp_pkg::*;
(
   // clock
   input  wire logic        mclk,
   // command port
   output ivp_cmd_s         cmd,
   input  wire logic [15:0] cmd_rdata,
   input  wire logic        cmd_ack
);
   initial cmd = '0;
   // request at an edge, release at the taking edge, answer sampled after it
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] q, output logic a);
      @(posedge mclk);
      cmd <= '{1'b1, w, c, d};
      @(posedge mclk);
      // valid is a one-cycle pulse; code and data stand until the answer is taken
      cmd.valid <= 1'b0;
      #1;
      a = cmd_ack;
      q = cmd_rdata;
   endtask
endmodule

// >>> bench/ivp_input_protect_tb.sv
`timescale 1ns/1ps
module ivp_input_protect_tb;
   import ivp_pkg::*;
   // bench signals
   logic        mclk, sys_rst, status_clear, nvm_restore, vin_valid, pwm_clk;
   logic        conv_enable, cmd_ack, switch_enable, smb_alert_n, ack;
   logic [15:0] cmd_rdata, nvm_ov_limit, nvm_uv_limit, rt, q;
   logic [7:0]  nvm_ov_action;
   logic [18:0] vin_sample;
   logic [39:0] bad [6];
   logic [15:0] dl [3];
   ivp_cmd_s    cmd;
   ivp_status_s status;
   int          failures, tests_run, i;

   ivp_host host (.mclk(mclk), .cmd(cmd), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack));
   ivp_input_protect uut (.mclk(mclk), .sys_rst(sys_rst), .cmd(cmd), .cmd_rdata(cmd_rdata),
      .cmd_ack(cmd_ack), .status_clear(status_clear), .nvm_restore(nvm_restore),
      .nvm_ov_limit(nvm_ov_limit), .nvm_uv_limit(nvm_uv_limit),
      .nvm_ov_action(nvm_ov_action), .vin_sample(vin_sample), .vin_valid(vin_valid),
      .pwm_clk(pwm_clk), .conv_enable(conv_enable), .soft_start_rise_time(rt),
      .switch_enable(switch_enable), .status(status), .smb_alert_n(smb_alert_n));

   ////////////////////////////////////////////////////////////////////////////////
   // clocks: switching clock free running, unrelated in phase
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      pwm_clk = 1'b0;
      #13;
      forever #40 pwm_clk = ~pwm_clk;
   end
   // watchdog: the whole sequence needs well under 100 us
   initial begin
      #400000;
      failures++;
      stop_test;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // compare tasks
   task automatic chk(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chb(input logic got, exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask
   // bus and stimulus tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      host.xfer(1'b1, c, d, q, ack);
      chb(ack, 1'b1);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      host.xfer(1'b0, c, 16'h0000, q, ack);
      chk(q, e);
   endtask
   task automatic smp(input logic [18:0] v);
      @(posedge mclk);
      vin_sample <= v;
      vin_valid  <= 1'b1;
      @(posedge mclk);
      vin_valid  <= 1'b0;
      cyc(1);
   endtask
   task automatic clr;
      @(posedge mclk);
      status_clear <= 1'b1;
      @(posedge mclk);
      status_clear <= 1'b0;
      cyc(1);
   endtask
   // bounded wait on the switching output
   task automatic sw_wait(input logic e, input int n);
      for (i = 0; i < n && switch_enable !== e; i++) cyc(1);
      chb(switch_enable, e);
   endtask
   // off command then on; a restart clears any latch-off
   task automatic restart(input logic e);
      @(posedge mclk);
      conv_enable <= 1'b0;
      cyc(4);
      @(posedge mclk);
      conv_enable <= 1'b1;
      cyc(20);
      chb(switch_enable, e);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence; vin is in sixteenths of a volt, 192 = 12 V
   initial begin
      {sys_rst, status_clear, nvm_restore, vin_valid, conv_enable} = 5'b10000;
      vin_sample = 19'd192;
      nvm_ov_limit = 16'hda07;   // 16.22 V, nearest step is 16.25 V
      nvm_uv_limit = 16'hf028;
      nvm_ov_action = 8'h80;
      rt = 16'h0002;
      failures = 0;
      tests_run = 0;
      bad = '{40'h55f010f040, 40'h55e881f040, 40'h55f059f040,
              40'h5600c00080, 40'h58f012f028, 40'h58f059f028};
      dl = '{16'h000f, 16'h0223, 16'h054b};   // delay code, on-time still expected
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      cyc(1);
      rd(8'h55, 16'hf058);
      rd(8'h56, 16'h0080);
      rd(8'h58, 16'hf00a);
      rd(8'h57, 16'h0000);
      chb(smb_alert_n, 1'b1);
      $display("reset values done");
      wr(8'h55, 16'hf040);
      wr(8'h58, 16'hf028);
      rd(8'h55, 16'hf040);
      rd(8'h58, 16'hf028);
      chk({11'h000, status}, 16'h0000);
      // refused writes leave the register alone and raise invalid data
      foreach (bad[k]) begin
         clr;
         wr(bad[k][39:32], bad[k][31:16]);
         cyc(1);
         chk({13'h0, status.catch_all_status_bit, status.invalid_data, smb_alert_n},
             16'h0006);
         rd(bad[k][39:32], bad[k][15:0]);
      end
      $display("refusals done");
      clr;
      smp(19'd272);
      chk({11'h000, status}, 16'h001c);
      chb(smb_alert_n, 1'b0);
      smp(19'd192);
      chk({11'h000, status}, 16'h001c);
      clr;
      smp(19'd144);
      chk({11'h000, status}, 16'h001a);
      smp(19'd192);
      $display("telemetry done");
      // delayed shutdown for codes 0, 2 and 5
      foreach (dl[k]) begin
         wr(8'h56, {13'h0008, dl[k][10:8]});
         restart(1'b1);
         smp(19'd272);
         cyc(dl[k][7:0]);
         chb(switch_enable, 1'b1);
         sw_wait(1'b0, 120);
         smp(19'd192);
      end
      // fault gone before the nine-cycle delay ends: switching carries on
      wr(8'h56, 16'h0045);
      restart(1'b1);
      smp(19'd272);
      smp(19'd192);
      cyc(120);
      chb(switch_enable, 1'b1);
      $display("delayed shutdown done");
      wr(8'h56, 16'h0080);
      restart(1'b1);
      smp(19'd272);
      sw_wait(1'b0, 40);
      smp(19'd192);
      cyc(200);
      chb(switch_enable, 1'b0);
      // one retry, restart_wait_period of three rise times of two periods
      wr(8'h56, 16'h008b);
      restart(1'b1);
      smp(19'd272);
      sw_wait(1'b0, 40);
      smp(19'd192);
      cyc(40);
      chb(switch_enable, 1'b0);
      sw_wait(1'b1, 60);
      // two hidden retries spent while the fault persists, then latched
      wr(8'h56, 16'h0090);
      smp(19'd272);
      sw_wait(1'b0, 40);
      cyc(100);
      chb(switch_enable, 1'b0);
      smp(19'd192);
      cyc(100);
      chb(switch_enable, 1'b0);
      wr(8'h56, 16'h00b8);
      restart(1'b1);
      smp(19'd272);
      sw_wait(1'b0, 40);
      cyc(300);
      smp(19'd192);
      sw_wait(1'b1, 80);
      wr(8'h56, 16'h0000);
      restart(1'b1);
      smp(19'd272);
      cyc(100);
      chb(switch_enable, 1'b1);
      restart(1'b0);
      smp(19'd192);
      $display("sequencer done");
      // restore rounds the overvoltage limit to the nearest quarter volt
      @(posedge mclk);
      conv_enable <= 1'b0;
      nvm_restore <= 1'b1;
      @(posedge mclk);
      nvm_restore <= 1'b0;
      clr;
      smp(19'd260);
      chb(status.input_overvoltage_status_bit, 1'b0);
      smp(19'd261);
      chb(status.input_overvoltage_status_bit, 1'b1);
      $display("restore done");
      stop_test;
   end
endmodule

// >>> hw/ivp_input_protect.sv
`timescale 1ns/1ps
module ivp_input_protect
   import ivp_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // host command port
   input  wire ivp_cmd_s    cmd,
   output logic [15:0]      cmd_rdata,
   output logic             cmd_ack,
   input  wire logic        status_clear,
   // store restore
   input  wire logic        nvm_restore,
   input  wire logic [15:0] nvm_ov_limit,
   input  wire logic [15:0] nvm_uv_limit,
   input  wire logic [7:0]  nvm_ov_action,
   // telemetry and converter control
   input  wire logic [18:0] vin_sample,
   input  wire logic        vin_valid,
   input  wire logic        pwm_clk,
   input  wire logic        conv_enable,
   input  wire logic [15:0] soft_start_rise_time,
   output logic             switch_enable,
   // status and alert
   output ivp_status_s      status,
   output logic             smb_alert_n
);

   ////////////////////////////////////////////////////////////////////////////
   // registers and decode
   logic [15:0]        input_overvoltage_fault_limit;     // linear word
   logic [7:0]         input_overvoltage_fault_action;    // action byte
   logic [15:0]        input_undervoltage_warning_limit;  // linear word
   logic               uv_locked;                         // raised above 5 V once
   logic signed [19:0] ov_q4;                             // decoded limits
   logic signed [19:0] uv_q4;
   logic signed [19:0] wr_q4;
   logic signed [19:0] rst_q;
   logic               ov_wr_ok;
   logic               uv_wr_ok;
   logic               act_wr_ok;
   logic               wr_hit;
   logic               wr_bad;
   ivp_action_e        ov_action_select;
   logic [2:0]         ov_restart_count;
   logic [2:0]         ov_shutdown_delay_code;

   assign ov_action_select       = ivp_action_e'(input_overvoltage_fault_action[7:6]);
   assign ov_restart_count       = input_overvoltage_fault_action[5:3];
   assign ov_shutdown_delay_code = input_overvoltage_fault_action[2:0];
   assign ov_q4 = ivp_lin_to_q4(input_overvoltage_fault_limit);
   assign uv_q4 = ivp_lin_to_q4(input_undervoltage_warning_limit);
   assign wr_q4 = ivp_lin_to_q4(cmd.data);
   // restore rounding: quarter volts, half step up
   assign rst_q = (ivp_lin_to_q4(nvm_ov_limit) + 20'sd2) >>> 2;

   // write checks; quarter steps means the low two sixteenth bits are zero
   assign ov_wr_ok  = wr_q4 >= IVP_LIM_MIN && wr_q4 <= IVP_LIM_MAX
                      && wr_q4[1:0] == 2'b00;
   assign uv_wr_ok  = wr_q4 >= IVP_LIM_MIN && wr_q4 <= IVP_LIM_MAX
                      && !(uv_locked && wr_q4 < IVP_LIM_MIN);
   assign act_wr_ok = cmd.data[7:6] != IVP_ACT_BAD;
   assign wr_hit    = cmd.valid && cmd.write;
   // unsupported writes never reach the register, they only flag
   assign wr_bad = wr_hit && ((cmd.code == IVP_CMD_OV_LIMIT && !ov_wr_ok)
                           || (cmd.code == IVP_CMD_OV_ACTION && !act_wr_ok)
                           || (cmd.code == IVP_CMD_UV_LIMIT && !uv_wr_ok));

   // limit and action registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         input_overvoltage_fault_limit    <= {IVP_EXP_RESET, IVP_OV_MAN_RESET};
         input_undervoltage_warning_limit <= {IVP_EXP_RESET, IVP_UV_MAN_RESET};
         input_overvoltage_fault_action   <= IVP_ACTION_RESET;
      end else if (nvm_restore) begin
         // restore snaps to the nearest supported quarter-volt step
         if (rst_q < IVP_Q_MIN)
            input_overvoltage_fault_limit <= {IVP_EXP_RESET, IVP_Q_MIN[10:0]};
         else if (rst_q > IVP_Q_MAX)
            input_overvoltage_fault_limit <= {IVP_EXP_RESET, IVP_Q_MAX[10:0]};
         else
            input_overvoltage_fault_limit <= {IVP_EXP_RESET, rst_q[10:0]};
         input_undervoltage_warning_limit <= nvm_uv_limit;
         input_overvoltage_fault_action   <= nvm_ov_action;
      end else if (wr_hit && !wr_bad) begin
         unique case (cmd.code)
            IVP_CMD_OV_LIMIT:  input_overvoltage_fault_limit    <= cmd.data;
            IVP_CMD_OV_ACTION: input_overvoltage_fault_action   <= cmd.data[7:0];
            IVP_CMD_UV_LIMIT:  input_undervoltage_warning_limit <= cmd.data;
            default: ;
         endcase
      end
   end

   // lockout once the warning limit has been placed above 5 V
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         uv_locked <= 1'b0;
      else if (wr_hit && !wr_bad && cmd.code == IVP_CMD_UV_LIMIT && wr_q4 > IVP_LIM_MIN)
         uv_locked <= 1'b1;
   end

   // read back, registered; unknown codes read zero
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_rdata <= 16'h0000;
         cmd_ack   <= 1'b0;
      end else begin
         cmd_ack <= cmd.valid;
         if (cmd.valid && !cmd.write) begin
            unique case (cmd.code)
               IVP_CMD_OV_LIMIT:  cmd_rdata <= input_overvoltage_fault_limit;
               IVP_CMD_OV_ACTION: cmd_rdata <= {8'h00, input_overvoltage_fault_action};
               IVP_CMD_UV_LIMIT:  cmd_rdata <= input_undervoltage_warning_limit;
               default:           cmd_rdata <= 16'h0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // switching clock sampled into mclk
   logic [2:0] pwm_sync;   // three stages, only stage 0 feeds stage 1
   logic       pwm_level;  // accepted level
   logic       pwm_edge;   // one mclk pulse per accepted rising edge

   // a change counts only when stages two and three agree
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pwm_sync  <= 3'h0;
         pwm_level <= 1'b0;
      end else begin
         pwm_sync <= {pwm_sync[1:0], pwm_clk};
         if (pwm_sync[1] == pwm_sync[2])
            pwm_level <= pwm_sync[2];
      end
   end
   assign pwm_edge = pwm_sync[1] && pwm_sync[2] && !pwm_level;

   ////////////////////////////////////////////////////////////////////////////
   // telemetry compare
   logic signed [19:0] vin_s;
   logic               ov_now;    // last sample above the fault limit
   logic               uv_now;    // last sample below the warning limit
   logic               ov_event;  // first sample that crosses
   logic               uv_event;

   assign vin_s    = {1'b0, vin_sample};
   assign ov_event = vin_valid && vin_s > ov_q4 && !ov_now;
   // each phase compares its own supply; no stack sharing here
   assign uv_event = vin_valid && vin_s < uv_q4 && !uv_now;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ov_now <= 1'b0;
         uv_now <= 1'b0;
      end else if (vin_valid) begin
         ov_now <= vin_s > ov_q4;
         uv_now <= vin_s < uv_q4;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky status; a set in the clear cycle wins
   ivp_status_s set_bits;

   always_comb begin
      set_bits = '0;
      set_bits.input_overvoltage_status_bit   = ov_event;
      set_bits.input_undervoltage_warning_bit = uv_event;
      set_bits.invalid_data                   = wr_bad;
      set_bits.catch_all_status_bit = ov_event || uv_event || wr_bad;
      set_bits.status_word_input    = ov_event || uv_event;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         status <= '0;
      else if (status_clear)
         status <= set_bits;
      else
         status <= status | set_bits;
   end
   // alert held while anything is flagged
   assign smb_alert_n = !(|status);

   ////////////////////////////////////////////////////////////////////////////
   // overvoltage response sequencer
   typedef enum logic [2:0] {
      IVP_OFF   = 3'b000,
      IVP_RUN   = 3'b001,
      IVP_DELAY = 3'b011,
      IVP_WAIT  = 3'b010,
      IVP_LATCH = 3'b110
   } ivp_state_e;

   ivp_state_e  state;
   ivp_state_e  next_state;
   logic [3:0]  dly_cycles;   // shutdown delay for the code
   logic [2:0]  hic_mult;     // restart_wait_period multiple of the rise time
   logic [18:0] hic_cycles;
   logic [18:0] count;        // switching cycles left in delay or wait
   logic [2:0]  attempts;     // failed restarts so far
   logic        retry_left;
   logic        shut_to;      // target after a shutdown: wait or latch

   // delay code table; codes 0 and 1 share the shortest settings
   always_comb begin
      if (ov_shutdown_delay_code <= 3'h1) begin
         dly_cycles = IVP_DLY_SHORT;
         hic_mult   = 3'h1;
      end else if (ov_shutdown_delay_code <= 3'h4) begin
         dly_cycles = IVP_DLY_MID;
         hic_mult   = ov_shutdown_delay_code;
      end else begin
         dly_cycles = IVP_DLY_LONG;
         hic_mult   = ov_shutdown_delay_code;
      end
   end
   assign hic_cycles = 19'(soft_start_rise_time) * 19'(hic_mult);
   assign retry_left = ov_restart_count == IVP_RETRY_FOREVER
                       || attempts + 3'h1 < ov_restart_count;
   assign shut_to    = ov_restart_count != 3'h0;

   // next state
   always_comb begin
      next_state = state;
      if (!conv_enable) begin
         next_state = IVP_OFF;
      end else begin
         unique case (state)
            IVP_OFF:   if (!ov_now) next_state = IVP_RUN;
            IVP_RUN: begin
               if (ov_event && ov_action_select == IVP_ACT_DELAYED)
                  next_state = IVP_DELAY;
               else if (ov_event && ov_action_select == IVP_ACT_IMMED)
                  next_state = shut_to ? IVP_WAIT : IVP_LATCH;
            end
            IVP_DELAY: begin
               if (pwm_edge && count == 19'h0)
                  next_state = !ov_now ? IVP_RUN
                             : shut_to ? IVP_WAIT : IVP_LATCH;
            end
            IVP_WAIT: begin
               if (pwm_edge && count == 19'h0 && !ov_now)
                  next_state = IVP_RUN;
               else if (pwm_edge && count == 19'h0 && !retry_left)
                  next_state = IVP_LATCH;
            end
            IVP_LATCH: next_state = IVP_LATCH;
            default:   next_state = IVP_OFF;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         state <= IVP_OFF;
      else
         state <= next_state;
   end

   // switching cycle counter, loaded on entry to delay or wait
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         count <= 19'h0;
      else if (next_state == IVP_DELAY && state != IVP_DELAY)
         count <= 19'(dly_cycles) - 19'h1;
      else if (next_state == IVP_WAIT && (state != IVP_WAIT || (pwm_edge && count == 19'h0)))
         count <= (hic_cycles == 19'h0) ? 19'h0 : hic_cycles - 19'h1;
      else if (pwm_edge && count != 19'h0)
         count <= count - 19'h1;
   end

   // hidden restarts still count; a good start clears the tally
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         attempts <= 3'h0;
      else if (state == IVP_OFF || next_state == IVP_RUN)
         attempts <= 3'h0;
      else if (state == IVP_WAIT && pwm_edge && count == 19'h0 && ov_now
               && attempts != IVP_RETRY_FOREVER)
         attempts <= attempts + 3'h1;
   end

   // switching stays on through the delay window
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         switch_enable <= 1'b0;
      else
         switch_enable <= next_state == IVP_RUN || next_state == IVP_DELAY;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_bad_write;
      wr_hit && wr_bad;
   endsequence
   sequence s_flag_raised;
      status.invalid_data && status.catch_all_status_bit && !smb_alert_n;
   endsequence

   a_bad_write_flag: assert property (@(posedge mclk) disable iff (sys_rst)
      s_bad_write |=> s_flag_raised)
      else $error("invalid write not flagged");
   a_bad_action_keep: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_hit && cmd.code == IVP_CMD_OV_ACTION && cmd.data[7:6] == 2'b11 && !nvm_restore
      |=> input_overvoltage_fault_action == $past(input_overvoltage_fault_action))
      else $error("unsupported action byte stored");
   a_ov_status_set: assert property (@(posedge mclk) disable iff (sys_rst)
      ov_event |=> status.input_overvoltage_status_bit && status.status_word_input
                   && status.catch_all_status_bit)
      else $error("overvoltage status bits not set");
   a_uv_status_set: assert property (@(posedge mclk) disable iff (sys_rst)
      uv_event |=> status.input_undervoltage_warning_bit && status.status_word_input)
      else $error("undervoltage status bits not set");
   a_status_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
      status.input_overvoltage_status_bit && !status_clear
      |=> status.input_overvoltage_status_bit)
      else $error("overvoltage status dropped without clear");
   a_ignore_runs: assert property (@(posedge mclk) disable iff (sys_rst)
      state == IVP_RUN && conv_enable && ov_action_select == IVP_ACT_IGNORE
      |=> state == IVP_RUN)
      else $error("ignore mode stopped switching");
   a_no_start_ov: assert property (@(posedge mclk) disable iff (sys_rst)
      state == IVP_OFF && ov_now |=> state != IVP_RUN)
      else $error("started with overvoltage present");
   a_zero_latches: assert property (@(posedge mclk) disable iff (sys_rst)
      state == IVP_RUN && conv_enable && ov_event && ov_restart_count == 3'h0
      && ov_action_select == IVP_ACT_IMMED |=> state == IVP_LATCH ##1 !switch_enable)
      else $error("restart count zero did not latch off");
   a_delay_short: assert property (@(posedge mclk) disable iff (sys_rst)
      state != IVP_DELAY && next_state == IVP_DELAY && ov_shutdown_delay_code <= 3'h1
      |=> count == 19'h2)
      else $error("short shutdown delay not three cycles");
   a_delay_switch: assert property (@(posedge mclk) disable iff (sys_rst)
      state == IVP_DELAY && conv_enable && count != 19'h0 |=> switch_enable)
      else $error("switching stopped inside delay window");
endmodule

// >>> hw/ivp_pkg.sv
// Contract
// - limit words: exponent resets -2, mantissa from store
// - out-of-range overvoltage limit write is invalid data
// - overvoltage limit 5 V to 22 V, quarter-volt steps
// - restore reloads nearest supported overvoltage step
// - overvoltage fault sets three status bits, alerts
// - action bits: ignore, delayed, immediate, unsupported
// - delayed mode switches on, then shuts if persisting
// - restart count zero latches off after shutdown
// - counts 1-6 retry after restart_wait_period, then latch
// - restarts during overvoltage are hidden but counted
// - count seven retries forever until off or success
// - delay codes 0-1: three cycles, one rise time
// - delay codes 2-4: five cycles, code rise times
// - delay codes 5-7: nine cycles, code rise times
// - ignore mode with fault at enable: no start
// - unsupported action byte write is invalid data
// - undervoltage warning detected per phase locally
// - undervoltage warning sets three status bits, alerts
// - warning limit default 2.5 V, writes 5-22 V
// - warning limit above 5 V locks out lower writes
// - restart_wait_period scaled by programmed soft-start rise time
package ivp_pkg;
   // command codes
   localparam logic [7:0]  IVP_CMD_OV_LIMIT  = 8'h55;
   localparam logic [7:0]  IVP_CMD_OV_ACTION = 8'h56;
   localparam logic [7:0]  IVP_CMD_UV_LIMIT  = 8'h58;
   // word fields and reset values
   localparam int          IVP_EXP_MSB       = 15;
   localparam int          IVP_EXP_LSB       = 11;
   localparam logic [4:0]  IVP_EXP_RESET     = 5'h1e;
   localparam logic [10:0] IVP_OV_MAN_RESET  = 11'h058;
   localparam logic [10:0] IVP_UV_MAN_RESET  = 11'h00a;
   localparam logic [7:0]  IVP_ACTION_RESET  = 8'h80;
   // limits in sixteenths of a volt
   localparam logic signed [19:0] IVP_LIM_MIN = 20'sh00050;
   localparam logic signed [19:0] IVP_LIM_MAX = 20'sh00160;
   // limits in quarter volts for restore rounding
   localparam logic signed [19:0] IVP_Q_MIN   = 20'sh00014;
   localparam logic signed [19:0] IVP_Q_MAX   = 20'sh00058;
   // shutdown delays in switching cycles
   localparam logic [3:0]  IVP_DLY_SHORT     = 4'h3;
   localparam logic [3:0]  IVP_DLY_MID       = 4'h5;
   localparam logic [3:0]  IVP_DLY_LONG      = 4'h9;
   localparam logic [2:0]  IVP_RETRY_FOREVER = 3'h7;

   // action select codes
   typedef enum logic [1:0] {
      IVP_ACT_IGNORE  = 2'b00,
      IVP_ACT_DELAYED = 2'b01,
      IVP_ACT_IMMED   = 2'b10,
      IVP_ACT_BAD     = 2'b11
   } ivp_action_e;

   // decoded host command from the bus front end
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } ivp_cmd_s;

   // sticky status bits
   typedef struct packed {
      logic catch_all_status_bit;
      logic status_word_input;
      logic input_overvoltage_status_bit;
      logic input_undervoltage_warning_bit;
      logic invalid_data;
   } ivp_status_s;

   // linear word to signed sixteenths of a volt
   function automatic logic signed [19:0] ivp_lin_to_q4(input logic [15:0] w);
      logic signed [5:0]  sh;
      logic signed [19:0] m;
      sh = {w[IVP_EXP_MSB], w[IVP_EXP_MSB:IVP_EXP_LSB]} + 6'sd4;
      m  = {{9{w[10]}}, w[10:0]};
      if (sh[5]) return m >>> (-sh);
      else return m <<< sh[4:0];
   endfunction
endpackage
